// *** logic/perf_cap_bus.sv ***
// Classic Wishbone answer timing: one ack cycle per request.
// Assumes the master drops stb after each acknowledged cycle.
`timescale 1ns/1ps

module perf_cap_bus
    import perf_cap_pkg::*;
(
    input wire logic ref_clk_i, // System clock.
    input wire logic rstn_i, // Asynchronous reset, active low.
    input wire logic req_i, // Cycle and strobe together.
    output logic ack_o // Acknowledge pulse.
);

    bus_state_type state_r;
    bus_state_type state_nxt;

    // Ack one cycle after the request, then drop for a cycle.
    always_comb begin
        case (state_r)
            BUS_IDLE: state_nxt = req_i ? BUS_ACK : BUS_IDLE;
            BUS_ACK: state_nxt = BUS_IDLE;
            default: state_nxt = BUS_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= BUS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ack_o = (state_r == BUS_ACK);

endmodule : perf_cap_bus

// *** logic/perf_cap_pkg.sv ***
// Constants, field layouts and the register map of the counter capability bank.
// Assumes a classic Wishbone slave with a 32-bit data path and byte addressing.

package perf_cap_pkg;

    // ==========================================================================
    // Register map.
    localparam logic [11:0] COUNTER_STRIDE = 12'h0100;
    localparam logic [7:0] CAP_OFFSET = 8'h80;
    localparam logic [7:0] EVCAP_OFFSET = 8'h84;
    localparam logic [7:0] EVCAP_STEP = 8'h04;
    localparam int MAX_EVENT_WORDS = 15;

    // ==========================================================================
    // Field positions.
    localparam int EVENT_GROUP_COUNT_LSB = 28;
    localparam int FREEZE_BIT = 17;
    localparam int OVF_INT_BIT = 16;
    localparam int WIDTH_LSB = 8;
    localparam int OVERRIDE_BIT = 0;
    localparam int EGI_LSB = 28;
    localparam logic [31:0] EVENTS_MASK = 32'h0FFF_FFFF;

    // ==========================================================================
    // Bus answer states.
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } bus_state_type;

endpackage : perf_cap_pkg

// *** logic/perf_cap_word.sv ***
// One counter's capability word and its event words, formed from fixed values.
// Assumes its parent gates presence with the global support flags.
`timescale 1ns/1ps

module perf_cap_word
    import perf_cap_pkg::*;
#(
    parameter logic [3:0] GROUPS = 4'h1,
    parameter logic FREEZE_OK = 1'b1,
    parameter logic OVF_INT_OK = 1'b1,
    parameter logic [7:0] WIDTH = 8'h30,
    parameter logic OVERRIDE = 1'b1,
    parameter logic [MAX_EVENT_WORDS*32-1:0] EVENT_WORDS = '0
) (
    input wire logic [3:0] word_sel_i, // Event word index.
    output logic [31:0] cap_o, // Counter capability word.
    output logic [31:0] evcap_o, // Selected event word, zero when absent.
    output logic [7:0] width_o // Effective local counter width.
);

    // Capability word assembly; reserved ranges stay zero.
    always_comb begin
        cap_o = '0;
        cap_o[EVENT_GROUP_COUNT_LSB +: 4] = GROUPS;
        cap_o[FREEZE_BIT] = FREEZE_OK;
        cap_o[OVF_INT_BIT] = OVF_INT_OK;
        cap_o[WIDTH_LSB +: 8] = WIDTH;
        cap_o[OVERRIDE_BIT] = OVERRIDE;
        width_o = WIDTH;
    end

    // Event word selection; group index is zero while the override is clear.
    always_comb begin
        evcap_o = '0;
        if (word_sel_i < GROUPS) begin
            evcap_o = EVENT_WORDS[word_sel_i*32 +: 32];
            if (!OVERRIDE) begin
                evcap_o = evcap_o & EVENTS_MASK;
            end
        end
    end

endmodule : perf_cap_word

// *** logic/perf_counter_capability_regs.sv ***
// Top of the read-only counter capability register bank on classic Wishbone.
// Assumes the global support flags are tied constants of the host unit.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps

module perf_counter_capability_regs
    import perf_cap_pkg::*;
#(
    parameter int NUM_COUNTERS = 4,
    parameter logic [11:0] CONFIG_BASE = 12'h000,
    parameter logic PERF_MON_SUPPORTED = 1'b1,
    parameter logic PER_COUNTER_SUPPORTED = 1'b1,
    parameter logic [3:0] GROUPS = 4'h2,
    parameter logic [7:0] WIDTH = 8'h30,
    parameter logic [MAX_EVENT_WORDS*32-1:0] EVENT_WORDS = {
        {13{32'h0000_0000}}, 32'h1000_00FF, 32'h0000_000F}
) (
    input wire logic ref_clk_i, // System clock, 10 MHz.
    input wire logic rstn_i, // Asynchronous reset, active low.
    input wire logic cyc_i, // Wishbone cycle.
    input wire logic stb_i, // Wishbone strobe.
    input wire logic we_i, // Wishbone write enable.
    input wire logic [3:0] sel_i, // Wishbone byte selects.
    input wire logic [11:0] adr_i, // Wishbone byte address.
    input wire logic [31:0] dat_i, // Wishbone write data, ignored.
    output logic [31:0] dat_o, // Wishbone read data.
    output logic ack_o, // Wishbone acknowledge.
    output logic [NUM_COUNTERS*8-1:0] width_o // Effective width per counter.
);

    // ==========================================================================
    // Per-counter words.
    logic [31:0] cap_w [NUM_COUNTERS];
    logic [31:0] ev_w [NUM_COUNTERS];
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic req_w;
    logic [11:0] rel_w;
    logic [3:0] word_w;
    logic present_w;
    logic unused_w;

    assign present_w = PERF_MON_SUPPORTED && PER_COUNTER_SUPPORTED;
    assign rel_w = adr_i - CONFIG_BASE;
    assign word_w = 4'((rel_w[7:0] - EVCAP_OFFSET) >> 2);
    assign unused_w = ^{dat_i, sel_i, we_i};

    // One word set per reported counter.
    genvar c;
    generate
        for (c = 0; c < NUM_COUNTERS; c++) begin : g_ctr
            perf_cap_word #(
                .GROUPS(GROUPS),
                .WIDTH(WIDTH),
                .EVENT_WORDS(EVENT_WORDS)
            ) u_word (
                .word_sel_i(word_w),
                .cap_o(cap_w[c]),
                .evcap_o(ev_w[c]),
                .width_o(width_o[c*8 +: 8])
            );
        end
    endgenerate

    // Read decode; writes and unmapped addresses return zero with an ack.
    always_comb begin
        dat_nxt = '0;
        if (present_w && req_w && !we_i) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                if (rel_w[11:8] == 4'(i)) begin
                    if (rel_w[7:0] == CAP_OFFSET) begin
                        dat_nxt = cap_w[i];
                    end else if (rel_w[7:0] >= EVCAP_OFFSET && rel_w[1:0] == 2'b00
                                 && rel_w[7:0] < EVCAP_OFFSET + {GROUPS, 2'b00}) begin
                        dat_nxt = ev_w[i];
                    end
                end
            end
        end
    end

    // Read data register.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dat_r <= '0;
        end else begin
            dat_r <= dat_nxt;
        end
    end

    assign req_w = cyc_i && stb_i && !ack_o;
    assign dat_o = dat_r;

    perf_cap_bus u_bus (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .req_i(req_w),
        .ack_o(ack_o)
    );

    // ==========================================================================
    // Checks.
    a_ack_follows_req: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ack_o |=> !ack_o)
        else $error("ack held too long");
    a_write_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        req_w && we_i |=> dat_o == 32'h0000_0000)
        else $error("write returned data");
    a_cap_read_value: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        req_w && !we_i && rel_w == 12'h080 && present_w |=> dat_o == cap_w[0])
        else $error("capability read wrong");
    a_cap_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (cap_w[0] & 32'h0FFC_00FE) == 32'h0000_0000)
        else $error("reserved bits set");
    a_groups_field: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cap_w[0][31:28] == GROUPS)
        else $error("group count wrong");
    a_width_field: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cap_w[0][15:8] == width_o[7:0])
        else $error("width mismatch");
    a_evword_read: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        req_w && !we_i && rel_w == 12'h084 && present_w |=> dat_o == ev_w[0])
        else $error("event word read wrong");
    a_absent_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !present_w |-> dat_nxt == 32'h0000_0000)
        else $error("absent bank returned data");

endmodule : perf_counter_capability_regs

// *** testbench/perf_counter_capability_regs_tb_top.sv ***
// Self-checking bench for the read-only counter capability register bank.
// Assumes the design package is compiled first and the bank answers classic Wishbone.
`timescale 1ns/1ps

module perf_counter_capability_regs_tb_top import perf_cap_pkg::*;;
    // ==========================================================================
    // Signals and expected words.
    localparam logic [31:0] CAP_EXP = 32'h2003_3001; // Two groups, freeze, int, 48 bits, local.
    localparam logic [31:0] EV0_EXP = 32'h0000_000F;
    localparam logic [31:0] EV1_EXP = 32'h1000_00FF;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] dat_on, dat_npc, dat_npm, rd_on, rd_npc, rd_npm;
    logic ack_on;
    logic [31:0] width_on;
    int miscompares = 0;
    int n_tests = 0;

    // ==========================================================================
    // One bank with full support, one without per-counter support, one without monitoring.
    perf_counter_capability_regs dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(dat_on),
        .ack_o(ack_on), .width_o(width_on));
    perf_counter_capability_regs #(.PER_COUNTER_SUPPORTED(1'b0)) dut_no_pcc (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
        .adr_i(adr), .dat_i(wdat), .dat_o(dat_npc), .ack_o(), .width_o());
    perf_counter_capability_regs #(.PERF_MON_SUPPORTED(1'b0)) dut_no_pm (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(sel),
        .adr_i(adr), .dat_i(wdat), .dat_o(dat_npm), .ack_o(), .width_o());

    // The clock toggles every 50 ns, half of its 100 ns period.
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ==========================================================================
    // Shared tasks.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb_cycle(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        // Look at ack and data mid-cycle, where they are settled; both still stand
        // at the following rising edge, which is the one that completes the cycle.
        do begin
            @(negedge ref_clk);
            n++;
        end while (ack_on !== 1'b1 && n < 50);
        if (ack_on !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: no acknowledge", $time);
        end
        rd_on = dat_on;
        rd_npc = dat_npc;
        rd_npm = dat_npm;
        @(posedge ref_clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb_cycle

    task automatic finish_test;
        $display("tests %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // ==========================================================================
    // Scenarios.
    task automatic t_cap_words;
        for (int c = 0; c < 4; c++) begin
            wb_cycle(1'b0, 12'(c * 256 + 128), 32'h0000_0000);
            check(rd_on, CAP_EXP, "capability word");
        end
        check(width_on, {4{8'h30}}, "effective width");
        $display("t_cap_words done");
    endtask : t_cap_words

    task automatic t_event_words;
        logic [31:0] ev [3];
        ev = '{EV0_EXP, EV1_EXP, 32'h0000_0000};
        for (int c = 0; c < 4; c++) begin
            for (int e = 0; e < 3; e++) begin
                wb_cycle(1'b0, 12'(c * 256 + 132 + 4 * e), 32'h0000_0000);
                check(rd_on, ev[e], "event word");
            end
        end
        $display("t_event_words done");
    endtask : t_event_words

    task automatic t_writes;
        wb_cycle(1'b1, 12'h080, 32'hFFFF_FFFF);
        check(rd_on, 32'h0000_0000, "write answer");
        wb_cycle(1'b1, 12'h184, 32'hFFFF_FFFF);
        wb_cycle(1'b0, 12'h080, 32'h0000_0000);
        check(rd_on, CAP_EXP, "capability after write");
        wb_cycle(1'b0, 12'h184, 32'h0000_0000);
        check(rd_on, EV0_EXP, "event word after write");
        $display("t_writes done");
    endtask : t_writes

    task automatic t_unmapped;
        logic [11:0] holes [4];
        holes = '{12'h000, 12'h07C, 12'h390, 12'h480};
        foreach (holes[i]) begin
            wb_cycle(1'b0, holes[i], 32'h0000_0000);
            check(rd_on, 32'h0000_0000, "unmapped address");
        end
        $display("t_unmapped done");
    endtask : t_unmapped

    task automatic t_absent;
        wb_cycle(1'b0, 12'h280, 32'h0000_0000);
        check(rd_npc, 32'h0000_0000, "no per-counter support");
        check(rd_npm, 32'h0000_0000, "no monitoring");
        wb_cycle(1'b0, 12'h288, 32'h0000_0000);
        check(rd_npc, 32'h0000_0000, "event word absent");
        check(rd_npm, 32'h0000_0000, "event word absent");
        check(rd_on, EV1_EXP, "event word present");
        $display("t_absent done");
    endtask : t_absent

    // Main sequence: reset for 8 cycles, then the scenarios.
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        t_cap_words();
        t_event_words();
        t_writes();
        t_unmapped();
        t_absent();
        finish_test();
    end

    // Watchdog well beyond the fewer than a hundred cycles the scenarios need.
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end
endmodule : perf_counter_capability_regs_tb_top
